// ---- verilog/rsc_pkg.sv ----
`default_nettype none
package rsc_pkg;
    // Register map: one register, offset chosen here
    localparam logic [31:0] REASON_ADDR = 32'h0000_0000;
    // Field positions within the reset-cause register
    localparam int POR_BIT = 0;
    localparam int BOR_BIT = 1;
    localparam int IDLE_BIT = 2;
    localparam int SLEEP_BIT = 3;
    localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
    localparam int WDEN_BIT = 5;
    localparam int INSTR_BIT = 6;
    localparam int PIN_BIT = 7;
    localparam int VREG_BIT = 8;
    localparam int ILL_BIT = 14;
    localparam int TRAP_BIT = 15;
    // Writable bits; 13..9 read as zero
    localparam logic [15:0] IMPL_MASK = 16'hc1ff;
    // Value after power-on: brown-out and power-on flags set
    localparam logic [15:0] POR_VALUE = 16'h0003;
    // Reset hold time
    localparam int CLK_MHZ = 40;
    localparam int HOLD_US = 20;
    localparam int HOLD_CYCLES = HOLD_US * CLK_MHZ;
    localparam int CNT_W = 10;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : rsc_pkg
`default_nettype wire

// ---- verilog/rsc_combiner.sv ----
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rsc_combiner #(
    parameter int HOLD = rsc_pkg::HOLD_CYCLES
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic arst_n, // Power-on reset, async, active low
    input wire logic brown_out, // Brown-out detector, active high
    input wire logic external_clear_pin_n, // Master clear pin, active low
    input wire logic reset_instruction, // Reset instruction executed
    input wire logic watchdog_timeout, // Watchdog expiry
    input wire logic trap_conflict, // Trap conflict event
    input wire logic illegal_access, // Illegal opcode / uninit pointer
    input wire logic power_save_sleep, // Sleep power-save instruction
    input wire logic power_save_idle, // Idle power-save instruction
    input wire logic watchdog_enable_fuse, // Config fuse, 1 = unprogrammed
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic master_system_reset, // Master reset, active high
    output logic watchdog_enable, // Watchdog runs
    output logic regulator_sleep_active // Regulator stays on in sleep
);
    localparam int N = 9;
    // Sync stages start with the fuse unprogrammed, so the watchdog never blinks off
    localparam logic [N-1:0] SYNC_INIT = 9'h100;

    // Source vector: 0 bor,1 pin,2 instr,3 wdt,4 trap,5 ill,6 sleep,7 idle,8 fuse
    logic [N-1:0] raw;
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    logic [N-1:0] rise;

    // One-cycle edges of the synchronised sources
    logic ev_bor;
    logic ev_pin;
    logic ev_instr;
    logic ev_wdt;
    logic ev_trap;
    logic ev_ill;
    logic ev_sleep;
    logic ev_idle;
    logic fuse_sync;
    logic clr_bor_class;
    logic clr_watchdog_timeout_flag;

    // Reset-cause register and reset stretch
    logic [15:0] reg_q;
    logic [15:0] reg_d;
    logic [15:0] wr_val;
    logic [rsc_pkg::CNT_W-1:0] cnt_q;
    logic any_src;
    logic hold_busy;

    // Bus decode
    logic wr_req;
    logic wr_pend_q;
    logic wr_hit_q;
    logic sw_wr;
    logic rd_req;
    logic addr_hit;

    // Pin reset is active low; invert before the synchroniser
    assign raw[0] = brown_out;
    assign raw[1] = ~external_clear_pin_n;
    assign raw[2] = reset_instruction;
    assign raw[3] = watchdog_timeout;
    assign raw[4] = trap_conflict;
    assign raw[5] = illegal_access;
    assign raw[6] = power_save_sleep;
    assign raw[7] = power_save_idle;
    assign raw[8] = watchdog_enable_fuse;

    // First synchroniser stage; only the second stage reads it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= SYNC_INIT;
        end else begin
            s1_q <= raw;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s2_q <= SYNC_INIT;
        end else begin
            s2_q <= s1_q;
        end
    end

    // Third stage only for edge detection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s3_q <= SYNC_INIT;
        end else begin
            s3_q <= s2_q;
        end
    end
    assign rise = s2_q & ~s3_q;
    assign fuse_sync = s2_q[8];

    // Named edges; a level source counts once per assertion
    assign ev_bor = rise[0];
    assign ev_pin = rise[1];
    assign ev_instr = rise[2];
    assign ev_wdt = rise[3];
    assign ev_trap = rise[4];
    assign ev_ill = rise[5];
    assign ev_sleep = rise[6];
    assign ev_idle = rise[7];
    assign clr_bor_class = ev_bor;
    assign clr_watchdog_timeout_flag = ev_bor || ev_sleep || ev_idle;

    // Reset-type sources; power-save and fuse bits excluded
    assign any_src = |s2_q[5:0];
    assign hold_busy = (cnt_q != '0);

    // Stretch counter reloads while a source stands, then runs down
    // Counter width must hold the hold count; the cast keeps the low bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= rsc_pkg::CNT_W'(HOLD);
        end else if (any_src) begin
            cnt_q <= rsc_pkg::CNT_W'(HOLD);
        end else if (hold_busy) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Reset output comes straight from a flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            master_system_reset <= 1'b1;
        end else begin
            master_system_reset <= any_src || hold_busy;
        end
    end

    // Write is performed in the data phase; only the decode result is kept
    assign addr_hit = (haddr[7:2] == rsc_pkg::REASON_ADDR[7:2]);
    assign wr_req = hsel && hwrite && htrans[1];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= wr_req;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_hit_q <= 1'b0;
        end else if (hready) begin
            wr_hit_q <= addr_hit;
        end
    end
    assign sw_wr = wr_pend_q && wr_hit_q;
    assign wr_val = hwdata[15:0] & rsc_pkg::IMPL_MASK;
    assign rd_req = hready && hsel && htrans[1] && !hwrite;

    // Software write first; a hardware set then wins in the same cycle
    // Limitation: a source still held after a software clear does not set again
    always_comb begin
        reg_d = reg_q;
        if (sw_wr) begin
            reg_d = wr_val;
        end

        // Trap conflict flag
        if (ev_trap) begin
            reg_d[rsc_pkg::TRAP_BIT] = 1'b1;
        end else if (clr_bor_class) begin
            reg_d[rsc_pkg::TRAP_BIT] = 1'b0;
        end

        // Illegal access flag
        if (ev_ill) begin
            reg_d[rsc_pkg::ILL_BIT] = 1'b1;
        end else if (clr_bor_class) begin
            reg_d[rsc_pkg::ILL_BIT] = 1'b0;
        end

        // Pin flag survives a brown-out; only power-on or a software write clears it
        if (ev_pin) begin
            reg_d[rsc_pkg::PIN_BIT] = 1'b1;
        end

        // Reset instruction flag
        if (ev_instr) begin
            reg_d[rsc_pkg::INSTR_BIT] = 1'b1;
        end else if (clr_bor_class) begin
            reg_d[rsc_pkg::INSTR_BIT] = 1'b0;
        end

        // Watchdog flag; a time-out beats a power-save in the same cycle
        if (ev_wdt) begin
            reg_d[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
        end else if (clr_watchdog_timeout_flag) begin
            reg_d[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        end

        // Power-save flags
        if (ev_sleep) begin
            reg_d[rsc_pkg::SLEEP_BIT] = 1'b1;
        end else if (clr_bor_class) begin
            reg_d[rsc_pkg::SLEEP_BIT] = 1'b0;
        end
        if (ev_idle) begin
            reg_d[rsc_pkg::IDLE_BIT] = 1'b1;
        end else if (clr_bor_class) begin
            reg_d[rsc_pkg::IDLE_BIT] = 1'b0;
        end

        // Brown-out flag; power-on sets it through the reset value
        if (ev_bor) begin
            reg_d[rsc_pkg::BOR_BIT] = 1'b1;
        end
    end

    // Register is not cleared by the reset it reports; only power-on resets it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_q <= rsc_pkg::POR_VALUE;
        end else begin
            reg_q <= reg_d;
        end
    end

    // Watchdog runs if the fuse is unprogrammed or software enables it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_enable <= 1'b1;
        end else begin
            watchdog_enable <= fuse_sync | reg_q[rsc_pkg::WDEN_BIT];
        end
    end

    // Regulator control mirrors its register bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulator_sleep_active <= 1'b0;
        end else begin
            regulator_sleep_active <= reg_q[rsc_pkg::VREG_BIT];
        end
    end

    // Read data from the next value, so a read right after a write sees it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= '0;
        end else if (rd_req) begin
            hrdata <= addr_hit ? {16'h0000, reg_d} : 32'h0000_0000;
        end
    end

    // No wait states; an always-ready slave keeps the master simple
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Every transfer is answered OKAY
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end
endmodule : rsc_combiner
`default_nettype wire

// ---- bench/rsc_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_chk #(parameter int HOLD = rsc_pkg::HOLD_CYCLES) (
    input wire logic clk, // Clock
    input wire logic arst_n, // Power-on
    input wire logic brown_out, // Src
    input wire logic external_clear_pin_n, // Src
    input wire logic reset_instruction, // Src
    input wire logic watchdog_timeout, // Src
    input wire logic trap_conflict, // Src
    input wire logic illegal_access, // Src
    input wire logic watchdog_enable_fuse, // Fuse
    input wire logic [31:0] hrdata, // Read data
    input wire logic master_system_reset, // Reset out
    input wire logic watchdog_enable // Wd out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic src = brown_out | !external_clear_pin_n | reset_instruction | watchdog_timeout
        | trap_conflict | illegal_access;
    logic [4:0] quiet_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            quiet_q <= 5'h00;
        end else begin
            quiet_q <= src ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1f};
        end
    end
    sequence s_rise; $rose(src); endsequence
    sequence s_drop; $fell(src) ##1 !src [*8] ##1 !src; endsequence
    a_src_assert: assert property (s_rise |-> ##[1:4] master_system_reset)
        else $error("no reset after source");
    a_src_level: assert property (src [*4] |-> master_system_reset)
        else $error("reset low with source held");
    a_hold_min: assert property ($fell(master_system_reset) |-> $past(master_system_reset, HOLD))
        else $error("reset released early");
    a_rel_bound: assert property (s_drop |-> !master_system_reset)
        else $error("reset released late");
    a_no_sw_reset: assert property (quiet_q > 5'h0c |-> !master_system_reset)
        else $error("reset without source");
    a_fuse_forces: assert property (watchdog_enable_fuse |=> watchdog_enable)
        else $error("fuse does not force watchdog");
    a_unimpl_zero: assert property (hrdata[31:16] == 16'h0 && hrdata[13:9] == 5'h0)
        else $error("unimplemented bits set");
    a_por_hold: assert property ($rose(arst_n) |-> master_system_reset)
        else $error("reset not held after power-on");
endmodule : rsc_chk
bind rsc_combiner rsc_chk #(.HOLD(HOLD)) u_chk (.clk(clk), .arst_n(arst_n),
    .brown_out(brown_out), .external_clear_pin_n(external_clear_pin_n),
    .reset_instruction(reset_instruction), .watchdog_timeout(watchdog_timeout),
    .trap_conflict(trap_conflict), .illegal_access(illegal_access),
    .watchdog_enable_fuse(watchdog_enable_fuse), .hrdata(hrdata),
    .master_system_reset(master_system_reset), .watchdog_enable(watchdog_enable));
`default_nettype wire

// ---- bench/rsc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
    input wire logic clk, // Clock
    input wire logic [2:0] sel, // Event kind
    input wire logic fire, // Start event
    output logic [7:0] ev // One-hot event lines
);
    logic [2:0] left_q;
    initial begin
        ev = 8'h00;
        left_q = 3'h0;
    end
    // Held several cycles so the sync stages cannot miss it
    always @(posedge clk) begin
        if (fire) begin
            ev <= 8'h01 << sel;
            left_q <= 3'h5;
        end else if (left_q != 3'h0) left_q <= left_q - 3'h1;
        else ev <= 8'h00;
    end
endmodule : rsc_src_model
`default_nettype wire

// ---- bench/test_rsc_combiner.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_reset_source_combiner_flags;
    logic clk = 1'b0, arst_n = 1'b0, fuse = 1'b1, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0, s;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, sel = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [7:0] ev;
    logic rdy, resp, msr, wden, regon;
    int mismatches = 0, total_checks = 0;
    logic [31:0] pre [8] = '{32'hc0df, 0, 0, 0, 0, 0, 32'h10, 32'h10};
    logic [31:0] exp [8] = '{32'h83, 32'h80, 32'h40, 32'h10, 32'h8000, 32'h4000, 32'h8, 32'h4};
    initial forever #12.5 clk = ~clk;
    rsc_combiner #(.HOLD(4)) uut (.clk(clk), .arst_n(arst_n), .brown_out(ev[0]),
        .external_clear_pin_n(!ev[1]), .reset_instruction(ev[2]), .watchdog_timeout(ev[3]),
        .trap_conflict(ev[4]), .illegal_access(ev[5]), .power_save_sleep(ev[6]),
        .power_save_idle(ev[7]), .watchdog_enable_fuse(fuse), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
        .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .master_system_reset(msr),
        .watchdog_enable(wden), .regulator_sleep_active(regon));
    rsc_src_model src (.clk(clk), .sel(sel), .fire(fire), .ev(ev));
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic wait_ready();
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rdy === 1'b1) return;
        end
        mismatches++;
        print_verdict();
    endtask : wait_ready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus
    // Reports whether the master reset was seen, then waits for its release
    task automatic settle();
        s = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            s |= msr;
            if (i > 12 && msr === 1'b0) return;
        end
        mismatches++;
        print_verdict();
    endtask : settle
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        settle();
        bus(0, 0, 0);
        check(rd, 32'h3);
        bus(1, 0, 32'hffffffff);
        bus(0, 0, 0);
        check(rd, 32'hc1ff);
        check({29'h0, regon, wden, msr}, 32'h6);
        fuse <= 1'b0;
        bus(1, 0, 0);
        bus(1, 32'h40, 32'hffff);
        check({31'h0, wden}, 32'h0);
        bus(0, 32'h40, 0);
        check(rd, 32'h0);
        bus(0, 0, 0);
        check(rd, 32'h0);
        for (int k = 0; k < 8; k++) begin
            bus(1, 0, pre[k]);
            fire <= 1'b1;
            sel <= k[2:0];
            @(posedge clk);
            fire <= 1'b0;
            settle();
            check({31'h0, s}, {31'h0, k < 6});
            bus(0, 0, 0);
            check(rd, exp[k]);
        end
        bus(1, 0, 32'hc1fe);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        settle();
        bus(0, 0, 0);
        check(rd, 32'h3);
        print_verdict();
    end
endmodule : test_reset_source_combiner_flags
`default_nettype wire
